// [rtl/ddscp_link.sv]
/*
  Serial-clock side of the command port: input shift register, bit count,
  word hand-off toward the system clock and the chained serial output.
  Assumes the serial clock stands still outside frames and that frame sync
  high acts as a reset of the shift path.
*/
`timescale 1ns/1ps
module ddscp_link
  import ddscp_pkg::*;
(
  input wire logic sclk_in,
  input wire logic rst_n_in,
  input wire logic frame_sync_n_in,
  input wire logic din_in,
  input wire logic chain_en_in,
  output logic [FRAME_BITS-1:0] word_out,
  output logic word_tog_out,
  output logic aligned_out,
  output logic sdo_out
);

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0] cnt;
  } ddscp_shift_t;

  typedef struct packed {
    logic [FRAME_BITS-1:0] word;
    logic tog;
    logic aligned;
  } ddscp_hold_t;

  typedef struct packed {
    logic chain_m;
    logic chain_s;
    logic serial_data_out;
  } ddscp_out_t;

  ddscp_shift_t sh_q, sh_d;
  ddscp_hold_t hd_q, hd_d;
  ddscp_out_t ou_q, ou_d;

  always_comb begin
    sh_d = sh_q;
    hd_d = hd_q;
    ou_d = ou_q;
    sh_d.shift = {sh_q.shift[FRAME_BITS-2:0], din_in}; // RULE_01 RULE_02
    sh_d.cnt = sh_q.cnt + 5'h01;
    // every 32nd bit hands a full word over; the system side picks which
    hd_d.aligned = (sh_q.cnt == 5'h1F); // RULE_18
    if (sh_q.cnt == 5'h1F) begin
      hd_d.word = sh_d.shift; // RULE_07
      hd_d.tog = ~hd_q.tog;
    end
    ou_d.chain_m = chain_en_in;
    ou_d.chain_s = ou_q.chain_m;
    ou_d.serial_data_out = ou_q.chain_s & sh_q.shift[FRAME_BITS-1]; // RULE_15
  end

  // frame sync high clears the partial word and blocks shifting
  always_ff @(negedge sclk_in or negedge rst_n_in or posedge frame_sync_n_in) begin
    if (!rst_n_in || frame_sync_n_in) begin
      sh_q <= '0; // RULE_13 RULE_19
    end else begin
      sh_q <= sh_d;
    end
  end

  // not cleared by frame sync, so the word outlives the frame end
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hd_q <= '0;
    end else if (!frame_sync_n_in) begin
      hd_q <= hd_d;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ou_q <= '0;
    end else begin
      ou_q <= ou_d; // RULE_16
    end
  end

  assign word_out = hd_q.word;
  assign word_tog_out = hd_q.tog;
  assign aligned_out = hd_q.aligned;
  assign sdo_out = ou_q.serial_data_out;

endmodule

// [rtl/ddscp_pkg.sv]
/*
  Package for the dual-channel converter serial command port: frame layout,
  command and channel-select encodings, clear codes and timing counts.
  Assumes a 200 MHz system clock and a serial clock that runs only in frames.
*/
package ddscp_pkg;

  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 5;
  localparam int CODE_BITS = 16;
  localparam int THERM_BITS = 15;
  localparam int LADDER_BITS = 12;

  // frame field positions, msb first on the wire
  localparam int CMD_HI = 27;
  localparam int SEL_HI = 23;
  localparam int CODE_HI = 19;
  localparam int PD_MODE_HI = 9;
  localparam int PD_CHAN_A_BIT = 0;
  localparam int PD_CHAN_B_BIT = 3;
  localparam int MASK_A_BIT = 0;
  localparam int MASK_B_BIT = 3;
  localparam int CLR_CODE_HI = 1;
  localparam int CHAIN_HI = 1;
  localparam int CHAIN_MODE_BIT = 1;

  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER = 4'h4;
  localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h6;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
  localparam logic [3:0] CMD_CHAIN = 4'h8;

  localparam logic [3:0] SEL_CHAN_A = 4'h0;
  localparam logic [3:0] SEL_CHAN_B = 4'h3;
  localparam logic [3:0] SEL_BOTH = 4'hF;

  localparam logic [1:0] CLR_TO_ZERO = 2'h0;
  localparam logic [1:0] CLR_TO_MID = 2'h1;
  localparam logic [1:0] CLR_TO_FULL = 2'h2;
  localparam logic [1:0] CLR_NOP = 2'h3;

  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;

  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] CHAIN_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // host-side timing, kept for the bench
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_RISE_MAX_PS = 30000;
  localparam int SYNC_GAP_MIN_PS = 1900000;
  localparam int SYNC_RISE_MAX_CYC = SYNC_RISE_MAX_PS / CLK_PERIOD_PS;
  localparam int SYNC_GAP_MIN_CYC = (SYNC_GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // cycles after reset release before the power-on level is trusted
  localparam logic [1:0] POR_SETTLE = 2'h3;

endpackage

// [rtl/ddscp_top.sv]
/*
  Dual-channel converter serial command port, system-clock side: decodes
  32-bit frames, keeps input and channel registers, power-down, clear code,
  load mask and chain mode, and feeds the thermometer and ladder switches.
  Assumes a 200 MHz CLK_IN; the serial clock, frame sync, load strobe, clear
  and power-on level pins are asynchronous to it. Frame sync must stay high
  for at least three system clocks between frames, or the sync edge is missed
  and two frames run together. A clear pulse must last at least three system
  clocks to be seen.
*/
// Summary of operation
// RULE_01 - shift data in on falling serial clock
// RULE_02 - frame: ignored, command, channel select, data
// RULE_03 - code left-justified, trailing bits ignored
// RULE_04 - select codes: A, B, both; others reserved
// RULE_05 - data commands write and update registers
// RULE_06 - control commands: power, clear, mask, reset, chain
// RULE_07 - execute command on 32nd falling edge
// RULE_08 - codes are straight unsigned binary
// RULE_09 - top four bits to fifteen thermometer lines
// RULE_10 - host raises sync within 30 ns
// RULE_11 - host holds sync high 1.9 us between
// RULE_12 - host may idle sync low between writes
// RULE_13 - early sync rise discards the frame
// RULE_14 - chain command bit one enables daisy-chain
// RULE_15 - chained bits beyond 32 leave on output
// RULE_16 - serial output changes on rising edges
// RULE_17 - host sends exactly 32 times N clocks
// RULE_18 - chained frame not multiple of 32 discarded
// RULE_19 - no shifting while sync is high
// RULE_20 - host clock bursts must be exact length
// RULE_21 - host pulses load strobe in chain mode
// RULE_22 - power command sets mode per channel
// RULE_23 - clear code stored; clear falling loads it
// RULE_24 - soft reset loads power-on code
// RULE_25 - load strobe low updates at frame end
// RULE_26 - reserved command or select changes nothing
`timescale 1ns/1ps
module ddscp_top
  import ddscp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SCLK_IN,
  input wire logic FRAME_SYNC_N_IN,
  input wire logic SERIAL_DATA_IN,
  input wire logic LOAD_STROBE_N_IN,
  input wire logic CLEAR_INPUT_N_IN,
  input wire logic POR_LEVEL_IN,
  output logic SERIAL_DATA_OUT,
  output logic [CODE_BITS-1:0] CHAN_A_CODE_OUT,
  output logic [CODE_BITS-1:0] CHAN_B_CODE_OUT,
  output logic [THERM_BITS-1:0] CHAN_A_THERM_OUT,
  output logic [THERM_BITS-1:0] CHAN_B_THERM_OUT,
  output logic [LADDER_BITS-1:0] CHAN_A_LADDER_OUT,
  output logic [LADDER_BITS-1:0] CHAN_B_LADDER_OUT,
  output logic [1:0] CHAN_A_PD_MODE_OUT,
  output logic [1:0] CHAN_B_PD_MODE_OUT,
  output logic [1:0] CHAIN_ENABLE_OUT
);

  typedef struct packed {
    logic tog_m;
    logic tog_s;
    logic tog_p;
    logic alg_m;
    logic alg_s;
    logic fs_m;
    logic fs_s;
    logic fs_p;
    logic fs_pp;
    logic ld_m;
    logic ld_s;
    logic clr_m;
    logic clr_s;
    logic clr_p;
    logic por_m;
    logic por_s;
    logic [1:0] por_cnt;
    logic pending;
    logic done;
    logic [CODE_BITS-1:0] in_a;
    logic [CODE_BITS-1:0] in_b;
    logic [CODE_BITS-1:0] dac_a;
    logic [CODE_BITS-1:0] dac_b;
    logic [1:0] pd_a;
    logic [1:0] pd_b;
    logic [1:0] clr_code;
    logic [1:0] mask;
    logic [1:0] chain;
    logic [THERM_BITS-1:0] therm_a;
    logic [THERM_BITS-1:0] therm_b;
    logic [LADDER_BITS-1:0] ladder_a;
    logic [LADDER_BITS-1:0] ladder_b;
  } ddscp_state_t;

  ddscp_state_t s_q, s_d;

  logic [FRAME_BITS-1:0] link_word;
  logic link_tog;
  logic link_aligned;
  logic link_sdo;

  // plain unsigned binary: the top nibble becomes a count of lines set
  function automatic logic [THERM_BITS-1:0] therm_of(input logic [CODE_BITS-1:0] code);
    logic [THERM_BITS-1:0] t;
    t = '0;
    for (int i = 0; i < THERM_BITS; i++) begin
      t[i] = (4'(i) < code[CODE_BITS-1 -: 4]); // RULE_08 RULE_09
    end
    return t;
  endfunction

  function automatic logic sel_hits_a(input logic [3:0] sel);
    return (sel == SEL_CHAN_A) || (sel == SEL_BOTH); // RULE_04
  endfunction

  function automatic logic sel_hits_b(input logic [3:0] sel);
    return (sel == SEL_CHAN_B) || (sel == SEL_BOTH); // RULE_04
  endfunction

  function automatic logic [CODE_BITS-1:0] clear_value(input logic [1:0] cc);
    logic [CODE_BITS-1:0] v;
    case (cc)
      CLR_TO_MID: v = CODE_MID;
      CLR_TO_FULL: v = CODE_FULL;
      default: v = CODE_ZERO;
    endcase
    return v;
  endfunction

  ddscp_link u_link (
    .sclk_in(SCLK_IN),
    .rst_n_in(RST_N_IN),
    .frame_sync_n_in(FRAME_SYNC_N_IN),
    .din_in(SERIAL_DATA_IN),
    .chain_en_in(s_q.chain[CHAIN_MODE_BIT]),
    .word_out(link_word),
    .word_tog_out(link_tog),
    .aligned_out(link_aligned),
    .sdo_out(link_sdo)
  );

  logic new_word;
  logic frame_end;
  logic clear_fall;
  logic chain_mode;
  logic exec;
  logic [3:0] cmd;
  logic [3:0] sel;
  logic [CODE_BITS-1:0] code;
  logic [CODE_BITS-1:0] por_code;
  logic hit_a;
  logic hit_b;
  logic [CODE_BITS-1:0] clr_val;

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers; edge detectors read only the second stage on
    s_d.tog_m = link_tog;
    s_d.tog_s = s_q.tog_m;
    s_d.tog_p = s_q.tog_s;
    s_d.alg_m = link_aligned;
    s_d.alg_s = s_q.alg_m;
    s_d.fs_m = FRAME_SYNC_N_IN;
    s_d.fs_s = s_q.fs_m;
    s_d.fs_p = s_q.fs_s;
    s_d.fs_pp = s_q.fs_p;
    s_d.ld_m = LOAD_STROBE_N_IN;
    s_d.ld_s = s_q.ld_m;
    s_d.clr_m = CLEAR_INPUT_N_IN;
    s_d.clr_s = s_q.clr_m;
    s_d.clr_p = s_q.clr_s;
    s_d.por_m = POR_LEVEL_IN;
    s_d.por_s = s_q.por_m;

    new_word = s_q.tog_s ^ s_q.tog_p;
    // one cycle later than the sync edge, so the aligned level has settled
    frame_end = s_q.fs_p & ~s_q.fs_pp;
    clear_fall = s_q.clr_p & ~s_q.clr_s;
    chain_mode = s_q.chain[CHAIN_MODE_BIT];
    // the word crosses unsynchronised: it stands for 32 serial clocks after
    // its toggle, far longer than the toggle takes through two flip-flops
    cmd = link_word[CMD_HI -: 4]; // RULE_02
    sel = link_word[SEL_HI -: 4];
    code = link_word[CODE_HI -: CODE_BITS]; // RULE_03
    por_code = s_q.por_s ? CODE_MID : CODE_ZERO;
    hit_a = sel_hits_a(sel);
    hit_b = sel_hits_b(sel);
    clr_val = clear_value(s_q.clr_code);

    // standalone: the first full word runs at once; chained: only at frame
    // end, and only if the bit count is a whole number of words
    exec = 1'b0;
    if (new_word) begin
      s_d.pending = 1'b1;
    end
    if (!chain_mode) begin
      if (new_word && !s_q.done) begin
        exec = 1'b1; // RULE_07
      end
    end else if (frame_end && (s_q.pending || new_word) && s_q.alg_s && !s_q.done) begin
      exec = 1'b1; // RULE_18
    end
    if (frame_end) begin
      s_d.pending = 1'b0;
      s_d.done = 1'b0;
    end else if (exec) begin
      s_d.done = 1'b1;
    end

    if (s_q.por_cnt != POR_SETTLE) begin
      // power-on level is caught only after its synchroniser has filled
      s_d.por_cnt = s_q.por_cnt + 2'h1;
      if (s_q.por_cnt == (POR_SETTLE - 2'h1)) begin
        s_d.in_a = por_code;
        s_d.in_b = por_code;
        s_d.dac_a = por_code;
        s_d.dac_b = por_code;
      end
    end

    if (exec) begin
      case (cmd)
        CMD_WRITE_IN: begin
          if (hit_a) s_d.in_a = code; // RULE_05 RULE_26
          if (hit_b) s_d.in_b = code;
        end
        CMD_UPDATE: begin
          if (hit_a) s_d.dac_a = s_q.in_a; // RULE_05
          if (hit_b) s_d.dac_b = s_q.in_b;
        end
        CMD_WRITE_UPD_ALL: begin
          // the other channel also takes what its input register holds
          if (hit_a || hit_b) begin
            s_d.in_a = hit_a ? code : s_q.in_a; // RULE_05
            s_d.in_b = hit_b ? code : s_q.in_b;
            s_d.dac_a = s_d.in_a;
            s_d.dac_b = s_d.in_b;
          end
        end
        CMD_WRITE_UPD: begin
          if (hit_a) begin
            s_d.in_a = code; // RULE_05
            s_d.dac_a = code;
          end
          if (hit_b) begin
            s_d.in_b = code;
            s_d.dac_b = code;
          end
        end
        CMD_POWER: begin
          // channel registers are left as they are
          if (link_word[PD_CHAN_A_BIT]) s_d.pd_a = link_word[PD_MODE_HI -: 2]; // RULE_22
          if (link_word[PD_CHAN_B_BIT]) s_d.pd_b = link_word[PD_MODE_HI -: 2];
        end
        CMD_CLEAR_CODE: begin
          s_d.clr_code = link_word[CLR_CODE_HI -: 2]; // RULE_06 RULE_23
        end
        CMD_LOAD_MASK: begin
          // a set mask bit keeps that channel deaf to the load strobe
          s_d.mask = {link_word[MASK_B_BIT], link_word[MASK_A_BIT]}; // RULE_06
        end
        CMD_SOFT_RESET: begin
          s_d.in_a = por_code; // RULE_24
          s_d.in_b = por_code;
          s_d.dac_a = por_code;
          s_d.dac_b = por_code;
        end
        CMD_CHAIN: begin
          s_d.chain = link_word[CHAIN_HI -: 2]; // RULE_14
        end
        default: begin
          // reserved codes use the frame up and move nothing else
          s_d.done = s_q.done | exec; // RULE_26
        end
      endcase
    end

    // load strobe low copies input to channel registers unless masked;
    // applied after the write so synchronous use updates on the same word
    if (!s_q.ld_s) begin
      if (!s_q.mask[0]) s_d.dac_a = s_d.in_a; // RULE_25
      if (!s_q.mask[1]) s_d.dac_b = s_d.in_b;
    end

    // clear wins over a frame in flight and aborts it; with sync high there
    // is no frame to abort, and setting done then would eat the next frame
    if (clear_fall) begin
      if (!s_q.fs_s) begin
        s_d.done = 1'b1;
      end
      if (s_q.clr_code != CLR_NOP) begin
        s_d.in_a = clr_val; // RULE_23
        s_d.in_b = clr_val;
        s_d.dac_a = clr_val;
        s_d.dac_b = clr_val;
      end
    end

    s_d.therm_a = therm_of(s_d.dac_a); // RULE_09
    s_d.therm_b = therm_of(s_d.dac_b);
    s_d.ladder_a = s_d.dac_a[LADDER_BITS-1:0]; // RULE_09
    s_d.ladder_b = s_d.dac_b[LADDER_BITS-1:0];
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      // synchronisers start at their pins' idle levels, so no false sync
      // edge, strobe or clear is seen while they fill after reset
      s_q <= '0;
      s_q.fs_m <= 1'b1;
      s_q.fs_s <= 1'b1;
      s_q.fs_p <= 1'b1;
      s_q.fs_pp <= 1'b1;
      s_q.ld_m <= 1'b1;
      s_q.ld_s <= 1'b1;
      s_q.clr_m <= 1'b1;
      s_q.clr_s <= 1'b1;
      s_q.clr_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign SERIAL_DATA_OUT = link_sdo;
  assign CHAN_A_CODE_OUT = s_q.dac_a;
  assign CHAN_B_CODE_OUT = s_q.dac_b;
  assign CHAN_A_THERM_OUT = s_q.therm_a;
  assign CHAN_B_THERM_OUT = s_q.therm_b;
  assign CHAN_A_LADDER_OUT = s_q.ladder_a;
  assign CHAN_B_LADDER_OUT = s_q.ladder_b;
  assign CHAN_A_PD_MODE_OUT = s_q.pd_a;
  assign CHAN_B_PD_MODE_OUT = s_q.pd_b;
  assign CHAIN_ENABLE_OUT = s_q.chain;

endmodule

// [tb/ddscp_host.sv]
/*
  Serial master model: sync, gated serial clock and data, msb first.
  Assumes the caller waits for each frame task to return before the next.
*/
`timescale 1ns/1ps
module ddscp_host (
  output logic sclk_out,
  output logic sync_n_out,
  output logic din_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    din_out = 1'b0;
  end
  // clock stands high outside frames; odd start offset keeps it off the system edges
  // park_low idles sync low after the frame; the next frame raises it first
  task automatic frame(input logic [63:0] w, input int n, output logic [31:0] cap,
      input bit park_low = 1'b0);
    cap = 32'h0;
    if (!sync_n_out) begin
      sync_n_out = 1'b1;
      #100;
    end
    #1.3 sync_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      #24 sclk_out = 1'b1;
      din_out = w[63-i];
      #24 sclk_out = 1'b0;
      if (i >= 32) begin
        cap = {cap[30:0], sdo_in};
      end
    end
    #10 sync_n_out = 1'b1;
    din_out = ~din_out;
    #14 sclk_out = 1'b1;
    #2000;
    if (park_low) begin
      sync_n_out = 1'b0;
    end
  endtask
endmodule

// [tb/ddscp_top_monitor.sv]
/*
  Checker for the command port top: switch outputs, quiet-time stability,
  chained output timing and reset defaults.
  Assumes it is bound to ddscp_top and sees only its ports.
*/
`timescale 1ns/1ps
module ddscp_top_monitor
  import ddscp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SCLK_IN,
  input wire logic FRAME_SYNC_N_IN,
  input wire logic LOAD_STROBE_N_IN,
  input wire logic CLEAR_INPUT_N_IN,
  input wire logic POR_LEVEL_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic [CODE_BITS-1:0] CHAN_A_CODE_OUT,
  input wire logic [CODE_BITS-1:0] CHAN_B_CODE_OUT,
  input wire logic [THERM_BITS-1:0] CHAN_A_THERM_OUT,
  input wire logic [THERM_BITS-1:0] CHAN_B_THERM_OUT,
  input wire logic [LADDER_BITS-1:0] CHAN_A_LADDER_OUT,
  input wire logic [LADDER_BITS-1:0] CHAN_B_LADDER_OUT,
  input wire logic [1:0] CHAN_A_PD_MODE_OUT,
  input wire logic [1:0] CHAN_B_PD_MODE_OUT,
  input wire logic [1:0] CHAIN_ENABLE_OUT
);
  // cycles with sync, strobe and clear all idle; long enough to cover sync lag
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  always_comb begin
    quiet_d = quiet_q + {3'h0, quiet_q != 4'hF};
    if (!(FRAME_SYNC_N_IN && LOAD_STROBE_N_IN && CLEAR_INPUT_N_IN)) begin
      quiet_d = 4'h0;
    end
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_por_hold;
    (CHAN_A_CODE_OUT == CODE_ZERO && CHAN_B_CODE_OUT == CODE_ZERO) [*2];
  endsequence
  sequence s_por_load;
    CHAN_A_CODE_OUT == (POR_LEVEL_IN ? CODE_MID : CODE_ZERO);
  endsequence
  AST_THERM: assert property (
    CHAN_A_THERM_OUT == 15'((16'h1 << CHAN_A_CODE_OUT[15:12]) - 16'h1)
    && CHAN_B_THERM_OUT == 15'((16'h1 << CHAN_B_CODE_OUT[15:12]) - 16'h1))
    else $error("thermometer lines disagree with code");
  AST_LADDER: assert property (
    CHAN_A_LADDER_OUT == CHAN_A_CODE_OUT[11:0] && CHAN_B_LADDER_OUT == CHAN_B_CODE_OUT[11:0])
    else $error("ladder lines disagree with code");
  AST_CODE_QUIET: assert property (
    quiet_q > 4'hB |-> $stable(CHAN_A_CODE_OUT) && $stable(CHAN_B_CODE_OUT))
    else $error("code changed with the port idle");
  AST_MODE_QUIET: assert property (
    quiet_q > 4'hB |-> $stable(CHAN_A_PD_MODE_OUT) && $stable(CHAN_B_PD_MODE_OUT)
    && $stable(CHAIN_ENABLE_OUT))
    else $error("mode changed with the port idle");
  AST_SDO_IDLE: assert property (
    (!CHAIN_ENABLE_OUT[1]) [*8] |-> !SERIAL_DATA_OUT)
    else $error("serial output active in standalone mode");
  AST_SDO_EDGE: assert property (
    $changed(SERIAL_DATA_OUT) && !FRAME_SYNC_N_IN |-> SCLK_IN)
    else $error("serial output moved off the rising clock");
  AST_POR_LOAD: assert property (
    $rose(RST_N_IN) |-> s_por_hold ##[1:4] s_por_load)
    else $error("power-on code not loaded in time");
  AST_MODE_RESET: assert property (
    $rose(RST_N_IN) |-> CHAIN_ENABLE_OUT == CHAIN_RESET
    && CHAN_A_PD_MODE_OUT == PD_NORMAL && CHAN_B_PD_MODE_OUT == PD_NORMAL)
    else $error("mode not at default after reset");
endmodule

// [tb/dual_dac_serial_command_port_bench.sv]
/*
  Self-checking bench for the command port: random and corner frames.
  Assumes the host model in ddscp_host and the checker bound below.
*/
`timescale 1ns/1ps
module dual_dac_serial_command_port_bench
  import ddscp_pkg::*;
;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic LOAD_STROBE_N_IN = 1'b1;
  logic CLEAR_INPUT_N_IN = 1'b1;
  logic POR_LEVEL_IN = 1'b1;
  logic SCLK_IN, FRAME_SYNC_N_IN, SERIAL_DATA_IN, SERIAL_DATA_OUT;
  logic [CODE_BITS-1:0] CHAN_A_CODE_OUT, CHAN_B_CODE_OUT;
  logic [THERM_BITS-1:0] CHAN_A_THERM_OUT, CHAN_B_THERM_OUT;
  logic [LADDER_BITS-1:0] CHAN_A_LADDER_OUT, CHAN_B_LADDER_OUT;
  logic [1:0] CHAN_A_PD_MODE_OUT, CHAN_B_PD_MODE_OUT, CHAIN_ENABLE_OUT;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'hB2E9FEDE;
  logic [3:0] sels [3] = '{SEL_CHAN_A, SEL_CHAN_B, SEL_BOTH};
  logic [15:0] ea, eb, c;
  logic [31:0] cap, w1;

  always #2.5 CLK_IN = ~CLK_IN;

  ddscp_top DUT (.CLK_IN, .RST_N_IN, .SCLK_IN, .FRAME_SYNC_N_IN, .SERIAL_DATA_IN,
    .LOAD_STROBE_N_IN, .CLEAR_INPUT_N_IN, .POR_LEVEL_IN, .SERIAL_DATA_OUT,
    .CHAN_A_CODE_OUT, .CHAN_B_CODE_OUT, .CHAN_A_THERM_OUT, .CHAN_B_THERM_OUT,
    .CHAN_A_LADDER_OUT, .CHAN_B_LADDER_OUT, .CHAN_A_PD_MODE_OUT,
    .CHAN_B_PD_MODE_OUT, .CHAIN_ENABLE_OUT);
  ddscp_host u_host (.sclk_out(SCLK_IN), .sync_n_out(FRAME_SYNC_N_IN),
    .din_out(SERIAL_DATA_IN), .sdo_in(SERIAL_DATA_OUT));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ignored top nibble is random so a decoder that reads it gets caught
  function automatic logic [31:0] mk(input logic [3:0] cmd, input logic [3:0] sel,
      input logic [19:0] d);
    return {seed[3:0], cmd, sel, d};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic chk_codes();
    chk("chan_a_code", ea, CHAN_A_CODE_OUT);
    chk("chan_b_code", eb, CHAN_B_CODE_OUT);
  endtask

  task automatic send(input logic [31:0] w, input int n = 32, input bit park = 1'b0);
    u_host.frame({w, 32'h0}, n, cap, park);
    seed = lfsr(seed);
    repeat (10) @(negedge CLK_IN);
  endtask

  task automatic pulse_clear();
    CLEAR_INPUT_N_IN = 1'b0;
    repeat (10) @(negedge CLK_IN);
    CLEAR_INPUT_N_IN = 1'b1;
  endtask

  task automatic close_out();
    $display("mismatches %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge CLK_IN);
    RST_N_IN = 1'b1;
    repeat (8) @(negedge CLK_IN);
    ea = CODE_MID;
    eb = CODE_MID;
    chk_codes();
    chk("chain", {14'h0, CHAIN_RESET}, {14'h0, CHAIN_ENABLE_OUT});
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? CODE_FULL : (i == 1) ? CODE_ZERO : seed[31:16];
      send(mk(CMD_WRITE_UPD, sels[i % 3], {c, seed[7:4]}));
      if (i % 3 != 1) ea = c;
      if (i % 3 != 0) eb = c;
      chk_codes();
    end
    c = seed[15:0];
    send(mk(CMD_WRITE_IN, SEL_CHAN_A, {c, 4'h0}), 32, 1'b1);
    chk_codes();
    send(mk(CMD_UPDATE, SEL_CHAN_A, 20'h0));
    ea = c;
    chk_codes();
    c = seed[15:0];
    send(mk(CMD_WRITE_IN, SEL_CHAN_B, {c, 4'h0}));
    send(mk(CMD_WRITE_UPD_ALL, SEL_CHAN_A, {~c, 4'h0}));
    ea = ~c;
    eb = c;
    chk_codes();
    // one bit short, reserved selects, then every reserved command
    for (int k = 0; k < 10; k++) begin
      send(mk(k < 3 ? CMD_WRITE_UPD : 4'(k + 6), k < 3 ? 4'(k) : SEL_BOTH, 20'hFFFF0),
        k == 0 ? 31 : 32);
    end
    chk_codes();
    send(mk(CMD_POWER, 4'h0, 20'h00201));
    send(mk(CMD_POWER, 4'h0, 20'h00308));
    chk("pd_a", 16'h2, {14'h0, CHAN_A_PD_MODE_OUT});
    chk("pd_b", 16'h3, {14'h0, CHAN_B_PD_MODE_OUT});
    send(mk(CMD_LOAD_MASK, 4'h0, 20'h00001));
    c = seed[15:0];
    send(mk(CMD_WRITE_IN, SEL_BOTH, {c, 4'h0}));
    chk_codes();
    LOAD_STROBE_N_IN = 1'b0;
    repeat (10) @(negedge CLK_IN);
    LOAD_STROBE_N_IN = 1'b1;
    repeat (10) @(negedge CLK_IN);
    eb = c;
    chk_codes();
    send(mk(CMD_SOFT_RESET, 4'h0, 20'h0));
    ea = CODE_MID;
    eb = CODE_MID;
    chk_codes();
    POR_LEVEL_IN = 1'b0;
    send(mk(CMD_SOFT_RESET, 4'h0, 20'h0));
    ea = CODE_ZERO;
    eb = CODE_ZERO;
    chk_codes();
    send(mk(CMD_CLEAR_CODE, 4'h0, 20'h00002));
    pulse_clear();
    ea = CODE_FULL;
    eb = CODE_FULL;
    chk_codes();
    // no-op clear code: nothing moves, and the next frame must still be taken
    send(mk(CMD_CLEAR_CODE, 4'h0, 20'h00003));
    pulse_clear();
    chk_codes();
    send(mk(CMD_CHAIN, 4'h0, 20'h00002));
    chk("chain", 16'h2, {14'h0, CHAIN_ENABLE_OUT});
    w1 = mk(CMD_WRITE_UPD, SEL_CHAN_A, {seed[31:16], 4'h0});
    c = seed[15:0];
    u_host.frame({w1, mk(CMD_WRITE_UPD, SEL_CHAN_B, {c, 4'h0})}, 64, cap);
    repeat (10) @(negedge CLK_IN);
    eb = c;
    chk_codes();
    chk("sdo_hi", w1[31:16], cap[31:16]);
    chk("sdo_lo", w1[15:0], cap[15:0]);
    send(mk(CMD_WRITE_UPD, SEL_BOTH, 20'h0), 40);
    chk_codes();
    close_out();
  end

  initial begin
    #300000;
    fail_count++;
    close_out();
  end
endmodule

bind ddscp_top ddscp_top_monitor u_mon (.CLK_IN, .RST_N_IN, .SCLK_IN, .FRAME_SYNC_N_IN,
  .LOAD_STROBE_N_IN, .CLEAR_INPUT_N_IN, .POR_LEVEL_IN, .SERIAL_DATA_OUT,
  .CHAN_A_CODE_OUT, .CHAN_B_CODE_OUT, .CHAN_A_THERM_OUT, .CHAN_B_THERM_OUT,
  .CHAN_A_LADDER_OUT, .CHAN_B_LADDER_OUT, .CHAN_A_PD_MODE_OUT, .CHAN_B_PD_MODE_OUT,
  .CHAIN_ENABLE_OUT);
